/* File: bor_pkg.sv */
// package: constants for the brown-out reset control block
`default_nettype none
package bor_pkg;
  // register map
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  // field positions in the control register
  localparam int SW_EN_BIT = 7;
  localparam int FAST_START_BIT = 6;
  localparam int READY_BIT = 0;
  // reset values at power-on or brown-out reset
  localparam logic SW_EN_RST = 1'h1;
  localparam logic FAST_START_RST = 1'h0;
  // configuration mode codes
  typedef enum logic [1:0] {
    BOR_MODE_OFF = 2'b00,
    BOR_MODE_SW = 2'b01,
    BOR_MODE_NO_SLEEP = 2'b10,
    BOR_MODE_ON = 2'b11
  } bor_mode_e;
endpackage
`default_nettype wire

/* File: bor_ctrl.sv */
// brown-out reset control and status register block
`default_nettype none
module bor_ctrl (
  // clock and resets
  input wire logic clock,
  input wire logic srst,
  input wire logic other_rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // configuration and circuit
  input wire logic [1:0] brownout_mode_cfg,
  input wire logic sleep_active,
  input wire logic circuit_ready,
  output logic brownout_reset_en,
  output logic bandgap_force_on
);
  logic sw_brownout_enable_ff;
  logic brownout_fast_start_ff;
  logic ready_meta_ff;
  logic brownout_ready_flag_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] reg_value;
  logic hit;
  bor_pkg::bor_mode_e mode;

  assign mode = bor_pkg::bor_mode_e'(brownout_mode_cfg);
  assign hit = (addr == bor_pkg::ADDR_CONTROL);

  always_ff @(posedge clock) begin
    if (srst) begin
      sw_brownout_enable_ff <= bor_pkg::SW_EN_RST;
      brownout_fast_start_ff <= bor_pkg::FAST_START_RST;
    end else if (wr_en && hit) begin
      sw_brownout_enable_ff <= wdata[bor_pkg::SW_EN_BIT];
      brownout_fast_start_ff <= wdata[bor_pkg::FAST_START_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ready_meta_ff <= 1'h0;
      brownout_ready_flag_ff <= 1'h0;
    end else begin
      ready_meta_ff <= circuit_ready;
      brownout_ready_flag_ff <= ready_meta_ff;
    end
  end

  always_comb begin
    case (mode)
      bor_pkg::BOR_MODE_ON: brownout_reset_en = 1'b1;
      bor_pkg::BOR_MODE_OFF: brownout_reset_en = 1'b0;
      bor_pkg::BOR_MODE_NO_SLEEP: brownout_reset_en = !sleep_active;
      bor_pkg::BOR_MODE_SW: brownout_reset_en = sw_brownout_enable_ff;
      default: brownout_reset_en = 1'b0;
    endcase
  end

  always_comb begin
    case (mode)
      bor_pkg::BOR_MODE_NO_SLEEP: bandgap_force_on = brownout_fast_start_ff;
      bor_pkg::BOR_MODE_SW: bandgap_force_on = brownout_fast_start_ff;
      default: bandgap_force_on = 1'b0;
    endcase
  end

  always_comb begin
    reg_value = 8'h00;
    reg_value[bor_pkg::SW_EN_BIT] = sw_brownout_enable_ff;
    reg_value[bor_pkg::FAST_START_BIT] = brownout_fast_start_ff;
    reg_value[bor_pkg::READY_BIT] = brownout_ready_flag_ff;
    nxt_rdata = (rd_en && hit) ? reg_value : 8'h00;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= nxt_rdata;
    end
  end

  sequence s_ready_rise;
    $rose(circuit_ready) ##1 circuit_ready;
  endsequence

  sequence s_ready_fall;
    $fell(circuit_ready) ##1 !circuit_ready;
  endsequence

  sequence s_ctrl_write;
    wr_en && hit;
  endsequence

  sequence s_ctrl_read;
    rd_en && hit;
  endsequence

  sequence s_other_read;
    rd_en && !hit;
  endsequence

  sequence s_other_write;
    wr_en && !hit;
  endsequence

  sequence s_no_read;
    !rd_en;
  endsequence

  a_sw_mode_enable: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_SW) |-> brownout_reset_en == sw_brownout_enable_ff)
    else $error("software mode enable mismatch");
  a_sw_mode_on: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_SW) && sw_brownout_enable_ff |-> brownout_reset_en)
    else $error("software mode enable not on");
  a_sw_mode_off: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_SW) && !sw_brownout_enable_ff |-> !brownout_reset_en)
    else $error("software mode enable not off");
  a_sw_write_takes: assert property (@(posedge clock) disable iff (srst)
    s_ctrl_write ##1 (mode == bor_pkg::BOR_MODE_SW) |->
      brownout_reset_en == $past(wdata[bor_pkg::SW_EN_BIT]))
    else $error("software write did not switch enable");
  a_sw_awake_sleep: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_SW) && sleep_active |->
      brownout_reset_en == sw_brownout_enable_ff)
    else $error("sleep changed software mode enable");

  a_write_stores: assert property (@(posedge clock) disable iff (srst)
    wr_en && hit |=> sw_brownout_enable_ff == $past(wdata[7]))
    else $error("enable bit not stored");
  a_sw_bit_ignored: assert property (@(posedge clock) disable iff (srst)
    (mode != bor_pkg::BOR_MODE_SW) |-> brownout_reset_en ==
      ((mode == bor_pkg::BOR_MODE_ON) ||
      ((mode == bor_pkg::BOR_MODE_NO_SLEEP) && !sleep_active)))
    else $error("software bit acted outside software mode");
  a_enable_read: assert property (@(posedge clock) disable iff (srst)
    s_ctrl_read |=> rdata[7] == $past(sw_brownout_enable_ff))
    else $error("enable bit read mismatch");

  a_on_off_mode: assert property (@(posedge clock) disable iff (srst)
    brownout_mode_cfg[1] == brownout_mode_cfg[0] |-> brownout_reset_en == brownout_mode_cfg[1])
    else $error("fixed mode enable mismatch");
  a_always_on: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_ON) |-> brownout_reset_en)
    else $error("always-on mode not enabled");
  a_always_off: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_OFF) |-> !brownout_reset_en)
    else $error("always-off mode enabled");
  a_sleep_mode: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_NO_SLEEP) |-> brownout_reset_en == !sleep_active)
    else $error("sleep mode enable mismatch");
  a_sleep_awake_on: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_NO_SLEEP) && !sleep_active |-> brownout_reset_en)
    else $error("sleep mode not enabled while awake");
  a_sleep_asleep_off: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_NO_SLEEP) && sleep_active |-> !brownout_reset_en)
    else $error("sleep mode enabled while asleep");
  a_on_ignores_sleep: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_ON) && sleep_active |-> brownout_reset_en)
    else $error("always-on mode dropped in sleep");
  a_sleep_enable_src: assert property (@(posedge clock) disable iff (srst)
    sleep_active && brownout_reset_en |->
      (mode == bor_pkg::BOR_MODE_ON) || (mode == bor_pkg::BOR_MODE_SW))
    else $error("enabled in sleep by wrong mode");

  a_fast_write_stores: assert property (@(posedge clock) disable iff (srst)
    s_ctrl_write |=> brownout_fast_start_ff == $past(wdata[bor_pkg::FAST_START_BIT]))
    else $error("fast-start bit not stored");
  a_fixed_no_force: assert property (@(posedge clock) disable iff (srst)
    brownout_mode_cfg[1] == brownout_mode_cfg[0] |-> !bandgap_force_on)
    else $error("band-gap forced in fixed mode");
  a_on_no_force: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_ON) |-> !bandgap_force_on)
    else $error("band-gap forced in always-on mode");
  a_off_no_force: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_OFF) |-> !bandgap_force_on)
    else $error("band-gap forced in always-off mode");
  a_fast_read: assert property (@(posedge clock) disable iff (srst)
    s_ctrl_read |=> rdata[6] == $past(brownout_fast_start_ff))
    else $error("fast-start bit read mismatch");
  a_force_only_switch: assert property (@(posedge clock) disable iff (srst)
    bandgap_force_on |-> brownout_mode_cfg[1] != brownout_mode_cfg[0])
    else $error("band-gap forced outside switchable modes");

  a_force_follows: assert property (@(posedge clock) disable iff (srst)
    brownout_mode_cfg[1] != brownout_mode_cfg[0] |-> bandgap_force_on == brownout_fast_start_ff)
    else $error("band-gap force mismatch");
  a_force_set_sw: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_SW) && brownout_fast_start_ff |-> bandgap_force_on)
    else $error("band-gap not forced in software mode");
  a_force_set_sleep: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_NO_SLEEP) && brownout_fast_start_ff |-> bandgap_force_on)
    else $error("band-gap not forced in sleep mode");
  a_force_in_sleep: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_NO_SLEEP) && brownout_fast_start_ff && sleep_active |->
      bandgap_force_on)
    else $error("band-gap force dropped in sleep");
  a_force_sw_off: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_SW) && brownout_fast_start_ff && !sw_brownout_enable_ff |->
      bandgap_force_on)
    else $error("band-gap force dropped with enable off");

  a_force_clear_sw: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_SW) && !brownout_fast_start_ff |-> !bandgap_force_on)
    else $error("band-gap forced with fast-start clear");
  a_force_clear_sleep: assert property (@(posedge clock) disable iff (srst)
    (mode == bor_pkg::BOR_MODE_NO_SLEEP) && !brownout_fast_start_ff |-> !bandgap_force_on)
    else $error("band-gap forced in sleep mode with fast-start clear");
  a_force_write_clear: assert property (@(posedge clock) disable iff (srst)
    wr_en && hit && !wdata[bor_pkg::FAST_START_BIT] |=> !brownout_fast_start_ff)
    else $error("fast-start clear not stored");

  a_ready_read: assert property (@(posedge clock) disable iff (srst)
    rd_en && hit |=> rdata[0] == $past(brownout_ready_flag_ff))
    else $error("ready flag read mismatch");
  a_ready_set_read: assert property (@(posedge clock) disable iff (srst)
    s_ctrl_read ##0 brownout_ready_flag_ff |=> rdata[0])
    else $error("active circuit read as inactive");
  a_ready_clear_read: assert property (@(posedge clock) disable iff (srst)
    s_ctrl_read ##0 !brownout_ready_flag_ff |=> !rdata[0])
    else $error("inactive circuit read as active");

  a_read_zero_bits: assert property (@(posedge clock) disable iff (srst)
    rdata[5:1] == 5'h00)
    else $error("unimplemented bits read nonzero");
  a_other_addr_read: assert property (@(posedge clock) disable iff (srst)
    s_other_read |=> rdata == 8'h00)
    else $error("refused address read nonzero");
  a_idle_read_zero: assert property (@(posedge clock) disable iff (srst)
    s_no_read |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_other_addr_hold: assert property (@(posedge clock) disable iff (srst)
    s_other_write |=> $stable(sw_brownout_enable_ff) && $stable(brownout_fast_start_ff))
    else $error("refused address write changed bits");
  a_ready_no_write: assert property (@(posedge clock) disable iff (srst)
    !$past(srst) |-> brownout_ready_flag_ff == $past(ready_meta_ff))
    else $error("ready flag changed by other than synchroniser");

  a_reset_values: assert property (@(posedge clock)
    srst |=> sw_brownout_enable_ff && !brownout_fast_start_ff)
    else $error("reset values wrong");
  a_reset_ready_zero: assert property (@(posedge clock)
    srst |=> !brownout_ready_flag_ff && !ready_meta_ff)
    else $error("ready flag not cleared by reset");
  a_reset_rdata_zero: assert property (@(posedge clock)
    srst |=> rdata == 8'h00)
    else $error("read data not cleared by reset");
  a_other_rst_keep: assert property (@(posedge clock) disable iff (srst)
    other_rst && !wr_en |=> $stable(sw_brownout_enable_ff) && $stable(brownout_fast_start_ff))
    else $error("other reset changed control bits");
  a_idle_keeps: assert property (@(posedge clock) disable iff (srst)
    !wr_en |=> $stable(sw_brownout_enable_ff) && $stable(brownout_fast_start_ff))
    else $error("control bits changed without write");

  a_cfg_not_written: assert property (@(posedge clock) disable iff (srst)
    s_ctrl_write ##1 (mode == bor_pkg::BOR_MODE_OFF) |-> !brownout_reset_en)
    else $error("register write enabled always-off mode");
  a_cfg_on_write: assert property (@(posedge clock) disable iff (srst)
    s_ctrl_write ##1 (mode == bor_pkg::BOR_MODE_ON) |-> brownout_reset_en)
    else $error("register write disabled always-on mode");

  a_ready_sync: assert property (@(posedge clock) disable iff (srst)
    s_ready_rise |=> brownout_ready_flag_ff)
    else $error("ready flag not synchronised in two cycles");
  a_ready_clear_sync: assert property (@(posedge clock) disable iff (srst)
    s_ready_fall |=> !brownout_ready_flag_ff)
    else $error("ready flag not cleared in two cycles");
  a_ready_lag: assert property (@(posedge clock) disable iff (srst)
    !$past(srst) && !$past(srst, 2) |-> brownout_ready_flag_ff == $past(circuit_ready, 2))
    else $error("ready flag lag wrong");
  a_ready_meta_first: assert property (@(posedge clock) disable iff (srst)
    !$past(srst) |-> ready_meta_ff == $past(circuit_ready))
    else $error("first synchroniser stage wrong");
endmodule
`default_nettype wire

/* File: tb_bor_ctrl.sv */
// self-checking bench for the brown-out reset control block
`default_nettype none
module tb_bor_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, srst = 1, other_rst = 0, wr_en = 0, rd_en = 0, rd_q = 0;
  logic sleep_active = 0, circuit_ready = 0, brownout_reset_en, bandgap_force_on;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, sw;
  logic [1:0] brownout_mode_cfg = 2'h1;
  logic [1:0] m;
  logic exp_en;
  logic [7:0] notes[$];
  int failures = 0, compares = 0, seed = 22482;
  bor_ctrl i_dut (.clock(clock), .srst(srst), .other_rst(other_rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .brownout_mode_cfg(brownout_mode_cfg), .sleep_active(sleep_active),
    .circuit_ready(circuit_ready), .brownout_reset_en(brownout_reset_en),
    .bandgap_force_on(bandgap_force_on));
  always #10 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_en <= 1'h1;
    rd_en <= 1'h0;
    addr <= a;
    wdata <= d;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    rd_en <= 1'h1;
    wr_en <= 1'h0;
    addr <= a;
    notes.push_back(exp);
    @(posedge clock);
  endtask
  // read data checked in the cycle after the strobe, zero otherwise
  always @(posedge clock) rd_q <= rd_en;
  always @(negedge clock) begin
    if (rd_q) check(rdata, notes.pop_front());
    else check(rdata, 8'h00);
  end
  initial begin
    #100000;
    failures++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'h0;
    rd(4'h0, 8'h80);
    for (int i = 0; i < 16; i++) begin
      sw = $random(seed);
      sw[7] = i[3];
      m = i[1:0];
      wr(4'h0, sw);
      wr_en <= 1'h0;
      brownout_mode_cfg <= m;
      sleep_active <= i[2];
      @(negedge clock);
      exp_en = (m == 2'h3) || ((m == 2'h2) && !i[2]) || ((m == 2'h1) && sw[7]);
      check(brownout_reset_en, exp_en);
      check(bandgap_force_on, (m[0] ^ m[1]) && sw[6]);
      @(posedge clock);
      rd(4'h0, {sw[7:6], 6'h00});
    end
    circuit_ready <= 1'h1;
    rd_en <= 1'h0;
    repeat (3) @(posedge clock);
    rd(4'h0, {sw[7:6], 6'h01});
    rd_en <= 1'h0;
    other_rst <= 1'h1;
    @(posedge clock);
    other_rst <= 1'h0;
    rd(4'h0, {sw[7:6], 6'h01});
    rd_en <= 1'h0;
    circuit_ready <= 1'h0;
    srst <= 1'h1;
    repeat (3) @(posedge clock);
    srst <= 1'h0;
    wr(4'h5, 8'h00);
    rd(4'h5, 8'h00);
    rd(4'h0, 8'h80);
    rd_en <= 1'h0;
    repeat (3) @(posedge clock);
    test_done;
  end
endmodule
`default_nettype wire
